// File: bdma_pkg.sv
package bdma_pkg;
   localparam int ADDR_W          = 12;
   localparam int DATA_W          = 8;
   localparam int BANK_W          = 4;
   localparam int OFFS_W          = 8;
   localparam int MEM_BYTES       = 4096;
   localparam int GPR_BYTES       = 3904;
   localparam logic [11:0] SFR_BASE        = 12'hF40;
   localparam logic [11:0] SFR_TOP         = 12'hFFF;
   localparam logic [11:0] BANK_PTR_ADDR   = 12'hFE0;
   localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
   localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
   localparam logic [3:0]  USB_MGMT_BANK   = 4'h4;
   localparam logic [7:0]  BANK_PTR_RESET  = 8'h00;
   localparam logic [7:0]  READ_ZERO       = 8'h00;

   typedef enum logic [1:0] {
      BDMA_Q1,
      BDMA_Q2,
      BDMA_Q3,
      BDMA_Q4
   } bdma_phase_t;

   // One core data operation, presented for a whole instruction cycle.
   typedef struct packed {
      logic        valid;
      logic        accessSel;
      logic        fullMove;
      logic        bankLoad;
      logic [7:0]  offset;
      logic [11:0] srcAddr;
      logic [11:0] dstAddr;
      logic        writeEn;
      logic [7:0]  wrData;
   } bdma_core_req_t;

   typedef struct packed {
      logic        valid;
      logic        writeEn;
      logic [11:0] addr;
      logic [7:0]  wrData;
   } bdma_usb_req_t;
endpackage

// File: bdma_dual_ram.sv
`timescale 1ns/1ps
module bdma_dual_ram #(
   parameter int DEPTH  = bdma_pkg::GPR_BYTES,
   parameter int DATA_W = bdma_pkg::DATA_W
) (
   input  wire logic              clk_sys,
   input  wire logic [11:0]       coreAddr,
   input  wire logic              coreWr,
   input  wire logic [DATA_W-1:0] coreWrData,
   output      logic [DATA_W-1:0] coreRdData,
   input  wire logic [11:0]       usbAddr,
   input  wire logic              usbWr,
   input  wire logic [DATA_W-1:0] usbWrData,
   output      logic [DATA_W-1:0] usbRdData
);
   // No reset on the storage: contents are undefined at power-up and kept over resets.
   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      // The core write is placed last so it wins a same-address collision.
      if (usbWr && (int'(usbAddr) < DEPTH)) begin
         mem[usbAddr] <= usbWrData;
      end
      if (coreWr && (int'(coreAddr) < DEPTH)) begin
         mem[coreAddr] <= coreWrData;
      end
   end

   always_comb begin
      coreRdData = (int'(coreAddr) < DEPTH) ? mem[coreAddr] : bdma_pkg::READ_ZERO;
      usbRdData  = (int'(usbAddr) < DEPTH) ? mem[usbAddr] : bdma_pkg::READ_ZERO;
   end
endmodule

// File: bdma_addr_unit.sv
`timescale 1ns/1ps
module bdma_addr_unit (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire bdma_pkg::bdma_core_req_t  coreReq,
   input  wire logic                      extendedSetEnable,
   input  wire logic                      usbEnable,
   input  wire bdma_pkg::bdma_usb_req_t   usbReq,
   input  wire logic [7:0]                sfrRdData,
   output      logic [7:0]                coreRdData,
   output      logic [11:0]               coreAddr,
   output      logic                      statusUpdate,
   output      logic [7:0]                usbRdData,
   output      logic                      usbGrant,
   output      logic [11:0]               sfrAddr,
   output      logic                      sfrRd,
   output      logic                      sfrWr,
   output      logic [7:0]                sfrWrData,
   output      logic [7:0]                bankPointerRegister,
   output      logic [1:0]                phase
);
   bdma_pkg::bdma_phase_t phase_reg;
   logic [3:0]  bankPointerBits_reg;
   logic [7:0]  coreRdData_reg;
   logic [11:0] coreAddr_reg;
   logic        statusUpdate_reg;
   logic [7:0]  usbRdData_reg;
   logic        usbGrant_reg;
   logic [11:0] sfrAddr_reg;
   logic        sfrRd_reg;
   logic        sfrWr_reg;
   logic [7:0]  sfrWrData_reg;
   logic [11:0] srcAddr;
   logic [11:0] dstAddr;
   logic [7:0]  ramRdCore;
   logic [7:0]  ramRdUsb;
   logic        ramWrCore;
   logic        ramWrUsb;
   logic [11:0] ramAddrCore;
   logic [7:0]  opData;
   logic [7:0]  wrValue;

   // Banked or access-bank translation of an 8-bit operand.
   function automatic logic [11:0] mapAddr(input logic sel, input logic [3:0] bank,
                                           input logic [7:0] offs, input logic ext);
      logic [11:0] a;
      a = 12'h000;
      if (sel) begin
         a = {bank, offs};
      end else if (offs < bdma_pkg::ACCESS_SPLIT) begin
         // With the extended set the low window is reserved for indexed access;
         // that form is resolved upstream, so here it still points at bank 0.
         a = {bdma_pkg::ACCESS_LOW_BANK, offs};
      end else begin
         a = {bdma_pkg::ACCESS_HI_BANK, offs};
      end
      if (ext && !sel && offs < bdma_pkg::ACCESS_SPLIT) begin
         a = {bdma_pkg::ACCESS_LOW_BANK, offs};
      end
      return a;
   endfunction

   function automatic logic isSfr(input logic [11:0] a);
      return (a >= bdma_pkg::SFR_BASE) && (a <= bdma_pkg::SFR_TOP);
   endfunction

   function automatic logic isRam(input logic [11:0] a);
      return int'(a) < bdma_pkg::GPR_BYTES;
   endfunction

   always_comb begin
      srcAddr = coreReq.fullMove ? coreReq.srcAddr
                : mapAddr(coreReq.accessSel, bankPointerBits_reg, coreReq.offset, extendedSetEnable);
      dstAddr = coreReq.fullMove ? coreReq.dstAddr : srcAddr;
   end

   always_comb begin
      // Q2 presents the source, Q4 the destination.
      ramAddrCore = (phase_reg == bdma_pkg::BDMA_Q4) ? dstAddr : srcAddr;
      ramWrCore   = coreReq.valid && coreReq.writeEn && (phase_reg == bdma_pkg::BDMA_Q4)
                    && !coreReq.bankLoad && isRam(dstAddr);
      ramWrUsb    = usbEnable && usbReq.valid && usbReq.writeEn;
      wrValue     = coreReq.fullMove ? coreRdData_reg : coreReq.wrData;
      if (isRam(srcAddr)) begin
         opData = ramRdCore;
      end else if (srcAddr == bdma_pkg::BANK_PTR_ADDR) begin
         opData = {4'h0, bankPointerBits_reg};
      end else if (isSfr(srcAddr)) begin
         opData = sfrRdData;
      end else begin
         opData = bdma_pkg::READ_ZERO;
      end
   end

   bdma_dual_ram #(
      .DEPTH  (bdma_pkg::GPR_BYTES),
      .DATA_W (bdma_pkg::DATA_W)
   ) u_ram (
      .clk_sys    (clk_sys),
      .coreAddr   (ramAddrCore),
      .coreWr     (ramWrCore),
      .coreWrData (wrValue),
      .coreRdData (ramRdCore),
      .usbAddr    (usbReq.addr),
      .usbWr      (ramWrUsb),
      .usbWrData  (usbReq.wrData),
      .usbRdData  (ramRdUsb)
   );

   // Four quarter-phases make one instruction cycle.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= bdma_pkg::BDMA_Q1;
      end else begin
         case (phase_reg)
            bdma_pkg::BDMA_Q1: phase_reg <= bdma_pkg::BDMA_Q2;
            bdma_pkg::BDMA_Q2: phase_reg <= bdma_pkg::BDMA_Q3;
            bdma_pkg::BDMA_Q3: phase_reg <= bdma_pkg::BDMA_Q4;
            bdma_pkg::BDMA_Q4: phase_reg <= bdma_pkg::BDMA_Q1;
            default:           phase_reg <= bdma_pkg::BDMA_Q1;
         endcase
      end
   end

   // Only the low nibble exists, so upper-bit writes are lost by construction.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bankPointerBits_reg <= bdma_pkg::BANK_PTR_RESET[3:0];
      end else if (coreReq.valid && phase_reg == bdma_pkg::BDMA_Q4) begin
         if (coreReq.bankLoad) begin
            bankPointerBits_reg <= coreReq.wrData[3:0];
         end else if (coreReq.writeEn && dstAddr == bdma_pkg::BANK_PTR_ADDR) begin
            bankPointerBits_reg <= wrValue[3:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         coreRdData_reg <= 8'h00;
         coreAddr_reg   <= 12'h000;
      end else if (coreReq.valid && phase_reg == bdma_pkg::BDMA_Q2) begin
         coreRdData_reg <= opData;
         coreAddr_reg   <= srcAddr;
      end
   end

   // Status flags update on every operation except a pointer load, read or write alike, even if the target is absent.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         statusUpdate_reg <= 1'b0;
      end else begin
         statusUpdate_reg <= coreReq.valid && !coreReq.bankLoad && phase_reg == bdma_pkg::BDMA_Q4;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sfrAddr_reg   <= 12'h000;
         sfrRd_reg     <= 1'b0;
         sfrWr_reg     <= 1'b0;
         sfrWrData_reg <= 8'h00;
      end else begin
         sfrRd_reg <= coreReq.valid && phase_reg == bdma_pkg::BDMA_Q1 && isSfr(srcAddr)
                      && srcAddr != bdma_pkg::BANK_PTR_ADDR;
         sfrWr_reg <= coreReq.valid && coreReq.writeEn && !coreReq.bankLoad
                      && phase_reg == bdma_pkg::BDMA_Q3 && isSfr(dstAddr)
                      && dstAddr != bdma_pkg::BANK_PTR_ADDR;
         sfrAddr_reg   <= (phase_reg == bdma_pkg::BDMA_Q3) ? dstAddr : srcAddr;
         sfrWrData_reg <= wrValue;
      end
   end

   // The engine is answered one clock later; a lost write collision is flagged.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         usbRdData_reg <= 8'h00;
         usbGrant_reg  <= 1'b0;
      end else begin
         usbRdData_reg <= (usbEnable && isRam(usbReq.addr)) ? ramRdUsb : bdma_pkg::READ_ZERO;
         usbGrant_reg  <= usbEnable && usbReq.valid
                          && !(ramWrCore && ramWrUsb && ramAddrCore == usbReq.addr);
      end
   end

   assign coreRdData          = coreRdData_reg;
   assign coreAddr            = coreAddr_reg;
   assign statusUpdate        = statusUpdate_reg;
   assign usbRdData           = usbRdData_reg;
   assign usbGrant            = usbGrant_reg;
   assign sfrAddr             = sfrAddr_reg;
   assign sfrRd               = sfrRd_reg;
   assign sfrWr               = sfrWr_reg;
   assign sfrWrData           = sfrWrData_reg;
   assign bankPointerRegister = {4'h0, bankPointerBits_reg};
   assign phase               = phase_reg;
endmodule

// File: bdma_addr_unit_monitor.sv
`timescale 1ns/1ps
module bdma_addr_unit_monitor (
   input wire logic                     clk_sys,
   input wire logic                     rst_n,
   input wire bdma_pkg::bdma_core_req_t coreReq,
   input wire logic                     usbEnable,
   input wire bdma_pkg::bdma_usb_req_t  usbReq,
   input wire logic [11:0]              coreAddr,
   input wire logic                     statusUpdate,
   input wire logic [7:0]               usbRdData,
   input wire logic [11:0]              sfrAddr,
   input wire logic                     sfrRd,
   input wire logic                     sfrWr,
   input wire logic [7:0]               bankPointerRegister,
   input wire logic [1:0]               phase
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Plain single-byte operand fetches only; moves and pointer loads have their own checks.
   wire logic q2 = phase == 2'd1 && coreReq.valid && !coreReq.fullMove && !coreReq.bankLoad;
   AST_PTR_HI: assert property (bankPointerRegister[7:4] == 4'h0) else $error("pointer high nibble set");
   AST_PTR_LOAD: assert property (phase == 2'd3 && coreReq.valid && coreReq.bankLoad
      |=> bankPointerRegister == {4'h0, $past(coreReq.wrData[3:0])}) else $error("pointer load wrong");
   AST_PHASE: assert property (1'b1 |=> phase == $past(phase) + 2'd1) else $error("phase skipped");
   AST_SFR_RD: assert property (sfrRd |-> phase == 2'd1) else $error("read outside Q2");
   AST_SFR_WR: assert property (sfrWr |-> phase == 2'd3) else $error("write outside Q4");
   AST_SFR_WIN: assert property (sfrRd || sfrWr |-> sfrAddr >= 12'hF40) else $error("forward below window");
   AST_STATUS: assert property (statusUpdate |-> phase == 2'd0 && $past(phase) == 2'd3)
      else $error("status pulse misplaced");
   AST_BANKED: assert property (q2 && coreReq.accessSel
      |=> coreAddr == {$past(bankPointerRegister[3:0]), $past(coreReq.offset)}) else $error("banked address");
   AST_ACC_LO: assert property (q2 && !coreReq.accessSel && coreReq.offset < 8'h60
      |=> coreAddr == {4'h0, $past(coreReq.offset)}) else $error("access low address");
   AST_ACC_HI: assert property (q2 && !coreReq.accessSel && coreReq.offset >= 8'h60
      |=> coreAddr == {4'hF, $past(coreReq.offset)}) else $error("access high address");
   AST_MOVE: assert property (phase == 2'd1 && coreReq.valid && coreReq.fullMove
      |=> coreAddr == $past(coreReq.srcAddr)) else $error("move source address");
   AST_USB_ZERO: assert property (usbReq.valid && (!usbEnable || usbReq.addr >= 12'hF40)
      |=> usbRdData == 8'h00) else $error("usb read not zero");
endmodule
bind bdma_addr_unit bdma_addr_unit_monitor u_mon (.clk_sys, .rst_n, .coreReq, .usbEnable, .usbReq, .coreAddr,
   .statusUpdate, .usbRdData, .sfrAddr, .sfrRd, .sfrWr, .bankPointerRegister, .phase);

// File: bdma_sfr_model.sv
`timescale 1ns/1ps
// Special register block; left unreset so a read of a never-written place stays unknown.
module bdma_sfr_model (
   input  wire logic        clk_sys,
   input  wire logic [11:0] sfrAddr,
   input  wire logic        sfrWr,
   input  wire logic [7:0]  sfrWrData,
   output      logic [7:0]  sfrRdData
);
   logic [7:0] regs [256];
   always_ff @(posedge clk_sys) begin
      if (sfrWr) begin
         regs[sfrAddr[7:0]] <= sfrWrData;
      end
   end
   assign sfrRdData = regs[sfrAddr[7:0]];
endmodule

// File: bdma_addr_unit_tb_top.sv
`timescale 1ns/1ps
module bdma_addr_unit_tb_top;
   logic                     clk_sys, rst_n, extendedSetEnable, usbEnable, statusUpdate, usbGrant, sfrRd, sfrWr, s;
   bdma_pkg::bdma_core_req_t coreReq;
   bdma_pkg::bdma_usb_req_t  usbReq;
   logic [7:0]               sfrRdData, coreRdData, usbRdData, sfrWrData, bankPointerRegister, d;
   logic [11:0]              coreAddr, sfrAddr, a;
   logic [1:0]               phase;
   int                       err_count, n_checks;
   bdma_pkg::bdma_core_req_t rq[$];
   logic [20:0]              ex[$];
   bdma_addr_unit u_dut (.clk_sys, .rst_n, .coreReq, .extendedSetEnable, .usbEnable, .usbReq, .sfrRdData,
      .coreRdData, .coreAddr, .statusUpdate, .usbRdData, .usbGrant, .sfrAddr, .sfrRd, .sfrWr, .sfrWrData,
      .bankPointerRegister, .phase);
   bdma_sfr_model u_sfr (.clk_sys, .sfrAddr, .sfrWr, .sfrWrData, .sfrRdData);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [11:0] exp, input logic [11:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic bdma_pkg::bdma_core_req_t mk(logic c, f, b, logic [7:0] o, logic [11:0] sa, da,
                                                   logic we, logic [7:0] wd);
      return '{1'b1, c, f, b, o, sa, da, we, wd};
   endfunction
   // One instruction cycle from Q1, leaving the core side idle in the next Q1.
   task automatic op(input bdma_pkg::bdma_core_req_t r);
      @(posedge clk_sys iff phase == 2'd3);
      #1 coreReq = r;
      repeat (2) @(posedge clk_sys);
      #1 a = coreAddr;
      d = coreRdData;
      repeat (2) @(posedge clk_sys);
      #1 s = statusUpdate;
      coreReq = '0;
   endtask
   // The engine model keeps clear of bank 4 while enabled; a clock edge separates calls.
   task automatic usb(input logic we, input logic [11:0] ad, input logic [7:0] wd);
      @(posedge clk_sys);
      #1 usbReq = '{1'b1, we, ad, wd};
      @(posedge clk_sys);
      #1 usbReq = '0;
   endtask
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      coreReq = '0;
      usbReq = '0;
      extendedSetEnable = 1'b0;
      usbEnable = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      chk("pointer", 12'h000, {4'h0, bankPointerRegister});
      op(mk(0, 0, 1, 8'h00, 12'h000, 12'h000, 0, 8'hA5));
      chk("pointer", 12'h005, {4'h0, bankPointerRegister});
      rq = '{mk(1, 0, 0, 8'h10, 0, 0, 1, 8'h3C), mk(0, 0, 0, 8'h20, 0, 0, 1, 8'h11), mk(0, 0, 0, 8'h60, 0, 0, 1, 8'h77),
             mk(1, 0, 0, 8'h10, 0, 0, 0, 0), mk(0, 0, 0, 8'h20, 0, 0, 0, 0), mk(0, 0, 0, 8'h60, 0, 0, 0, 0),
             mk(0, 1, 0, 0, 12'h510, 12'h123, 1, 0), mk(0, 1, 0, 0, 12'h123, 12'h000, 1, 0),
             mk(0, 0, 0, 8'h40, 0, 0, 0, 0)};
      ex = '{{1'b0, 12'h510, 8'h00}, {1'b0, 12'h020, 8'h00}, {1'b0, 12'hF60, 8'h00}, {1'b1, 12'h510, 8'h3C},
             {1'b1, 12'h020, 8'h11}, {1'b1, 12'hF60, 8'h77}, {1'b1, 12'h510, 8'h3C}, {1'b1, 12'h123, 8'h3C},
             {1'b0, 12'h040, 8'h00}};
      foreach (rq[i]) begin
         op(rq[i]);
         chk("coreAddr", ex[i][19:8], a);
         if (ex[i][20]) chk("coreRdData", {4'h0, ex[i][7:0]}, {4'h0, d});
         chk("statusUpdate", 12'h001, {11'h0, s});
      end
      $display("table rows done");
      @(posedge clk_sys iff phase == 2'd3);
      #1 coreReq = mk(1, 0, 0, 8'h20, 0, 0, 1, 8'hAA);
      repeat (2) @(posedge clk_sys);
      #1 usb(1, 12'h520, 8'h55);
      coreReq = '0;
      chk("usbGrant", 12'h000, {11'h0, usbGrant});
      op(mk(1, 0, 0, 8'h20, 0, 0, 0, 0));
      chk("collision", 12'h0AA, {4'h0, d});
      usb(1, 12'h300, 8'h9C);
      usb(0, 12'h300, 8'h00);
      chk("usbRdData", 12'h09C, {4'h0, usbRdData});
      op(mk(0, 1, 0, 0, 12'h300, 12'h000, 1, 0));
      chk("shared", 12'h09C, {4'h0, d});
      usb(0, 12'hF40, 8'h00);
      chk("usbRdData", 12'h000, {4'h0, usbRdData});
      usbEnable = 1'b0;
      usb(0, 12'h300, 8'h00);
      chk("usbRdData", 12'h000, {4'h0, usbRdData});
      extendedSetEnable = 1'b1;
      op(mk(0, 0, 0, 8'h20, 0, 0, 0, 0));
      chk("extAddr", 12'h020, a);
      chk("extData", 12'h011, {4'h0, d});
      extendedSetEnable = 1'b0;
      $display("usb and collision done");
      rst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      chk("pointer", 12'h000, {4'h0, bankPointerRegister});
      op(mk(0, 0, 0, 8'h20, 0, 0, 0, 0));
      chk("retained", 12'h011, {4'h0, d});
      $display("reset retention done");
      wrap_up();
   end
endmodule
